// ---- dtmr_pkg.sv ----
// dual reload countdown timer package: register map, fields, timing constants
// assumes a byte-wide register port with plain strobes
package dtmr_pkg;
    // register offsets
    localparam logic [7:0] ADDR_RUN_CTRL    = 8'h0E;
    localparam logic [7:0] ADDR_T0_SETTINGS = 8'h0F;
    localparam logic [7:0] ADDR_T0_RLD_HI   = 8'h10;
    localparam logic [7:0] ADDR_T0_RLD_LO   = 8'h11;
    localparam logic [7:0] ADDR_T0_CNT_HI   = 8'h12;
    localparam logic [7:0] ADDR_T0_CNT_LO   = 8'h13;
    localparam logic [7:0] ADDR_T1_SETTINGS = 8'h14;
    localparam logic [7:0] ADDR_T1_RLD_HI   = 8'h15;
    localparam logic [7:0] ADDR_T1_RLD_LO   = 8'h16;
    localparam logic [7:0] ADDR_T1_CNT_HI   = 8'h17;
    localparam logic [7:0] ADDR_T1_CNT_LO   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'h31;

    // settings register fields
    localparam int HALT_RX_BIT  = 7;
    localparam int START_MSB    = 5;
    localparam int START_LSB    = 4;
    localparam int RELOAD_BIT   = 3;
    localparam int CLKSEL_MSB   = 1;
    localparam int CLKSEL_LSB   = 0;
    localparam logic [7:0] SETTINGS_MASK = 8'hBB;
    localparam logic [7:0] SETTINGS_RST  = 8'h00;
    localparam logic [7:0] RELOAD_RST    = 8'h00;

    // run control: upper nibble running bits, lower nibble write enables
    localparam int RUN_BASE = 4;

    // start modes
    localparam logic [1:0] START_SW      = 2'h0;
    localparam logic [1:0] START_TX_END  = 2'h1;
    localparam logic [1:0] START_TRIM    = 2'h2;
    localparam logic [1:0] START_TRIM_UF = 2'h3;

    // clock selects
    localparam logic [1:0] CLK_FAST  = 2'h0;
    localparam logic [1:0] CLK_SLOW  = 2'h1;
    localparam logic [1:0] CLK_CASC2 = 2'h2;
    localparam logic [1:0] CLK_CASC3 = 2'h3;

    // slow tick divider: 13.56 MHz / 211.875 kHz
    localparam int SLOW_TICK_DIV = 64;
    localparam int RX_HALT_BITS  = 4;

    // interrupt status bits
    localparam int IRQ_T0 = 0;
    localparam int IRQ_T1 = 1;
endpackage

// ---- dtmr_timer.sv ----
// one 16-bit reloadable down counter
// assumes start and stop inputs are one-cycle pulses on sys_clk; tick may be held high to count every cycle
module dtmr_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] reload_value,
    input  wire logic             start_pulse,
    input  wire logic             stop_pulse,
    input  wire logic             tick,
    input  wire logic             reload_on_zero,
    input  wire logic             wrap_on_zero,
    output logic [WIDTH-1:0]      count_q,
    output logic                  running_q,
    output logic                  underflow_q
);
    logic at_zero;
    assign at_zero = (count_q == '0);

    // counter: start loads, tick decrements, zero reloads, wraps or stops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q   <= '0;
            running_q <= 1'b0;
        end else if (start_pulse) begin
            count_q   <= reload_value;
            running_q <= 1'b1;
        end else if (stop_pulse) begin
            running_q <= 1'b0;
        end else if (running_q && tick) begin
            if (!at_zero) begin
                count_q <= count_q - 1'b1;
            end else if (reload_on_zero) begin
                count_q <= reload_value;
            end else if (wrap_on_zero) begin
                count_q <= count_q - 1'b1;
            end else begin
                running_q <= 1'b0;
            end
        end
    end

    // underflow pulse, one cycle, when a tick meets zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            underflow_q <= 1'b0;
        end else begin
            underflow_q <= running_q && tick && at_zero && !start_pulse && !stop_pulse;
        end
    end
endmodule

// ---- dtmr_top.sv ----
// dual reload countdown timers with register port and interrupt
// assumes rx/tx event inputs are synchronous pulses; trim edge input is a pin
//
// Design decision made here: the plain strobed port.
module dtmr_top #(
    parameter int WIDTH    = 16,
    parameter int SLOW_DIV = dtmr_pkg::SLOW_TICK_DIV
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    input  wire logic       rx_bit_pulse,
    input  wire logic       rx_frame_start,
    input  wire logic       tx_end_pulse,
    input  wire logic       trim_edge_pin,
    input  wire logic       timer2_underflow,
    output logic            irq,
    output logic            timer0_underflow,
    output logic            timer1_underflow
);
    // register storage
    logic [7:0] t0_settings_q;
    logic [7:0] t1_settings_q;
    logic [7:0] t0_rld_hi_q;
    logic [7:0] t0_rld_lo_q;
    logic [7:0] t1_rld_hi_q;
    logic [7:0] t1_rld_lo_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic [7:0] rdata_d;

    // timer state
    logic [WIDTH-1:0] t0_count;
    logic [WIDTH-1:0] t1_count;
    logic             t0_running;
    logic             t1_running;
    logic             t0_uf;
    logic             t1_uf;

    // sw start/stop pulses from run control writes
    logic [1:0] sw_start;
    logic [1:0] sw_stop;

    // slow tick divider
    logic [$clog2(SLOW_DIV)-1:0] div_q;
    logic                        slow_tick_q;

    // receive bit counter
    logic [2:0] rx_bits_q;
    logic       rx_halt_q;

    // trimming edge input synchroniser and edge detect
    logic trim_meta_q;
    logic trim_sync_q;
    logic trim_prev_q;
    logic trim_rise;

    // decoded fields
    function automatic logic [1:0] start_mode(input logic [7:0] s);
        return s[dtmr_pkg::START_MSB:dtmr_pkg::START_LSB];
    endfunction

    function automatic logic is_trim(input logic [7:0] s);
        return start_mode(s) == dtmr_pkg::START_TRIM || start_mode(s) == dtmr_pkg::START_TRIM_UF;
    endfunction

    function automatic logic pick_tick(input logic [1:0] sel, input logic slow,
                                       input logic casc2, input logic casc3);
        logic t;
        t = 1'b1;
        unique case (sel)
            dtmr_pkg::CLK_FAST:  t = 1'b1;
            dtmr_pkg::CLK_SLOW:  t = slow;
            dtmr_pkg::CLK_CASC2: t = casc2;
            dtmr_pkg::CLK_CASC3: t = casc3;
        endcase
        return t;
    endfunction

    // automatic start: transmit end, or a trim edge while idle
    function automatic logic auto_start(input logic [7:0] s, input logic tx_end,
                                        input logic pin_rise, input logic running);
        logic hit;
        hit = 1'b0;
        if (start_mode(s) == dtmr_pkg::START_TX_END && tx_end) begin
            hit = 1'b1;
        end
        if (is_trim(s) && pin_rise && !running) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // automatic stop: trim edge while running, or receive halt outside trimming
    function automatic logic auto_stop(input logic [7:0] s, input logic pin_rise,
                                       input logic running, input logic rx_halt);
        logic hit;
        hit = 1'b0;
        if (is_trim(s) && pin_rise && running) begin
            hit = 1'b1;
        end
        // trimming owns the pin edges, so the receive halt is ignored there
        if (s[dtmr_pkg::HALT_RX_BIT] && !is_trim(s) && rx_halt) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    logic wr_run;
    assign wr_run = reg_write && (reg_addr == dtmr_pkg::ADDR_RUN_CTRL);

    // run control: enable nibble gates each running bit
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            sw_start[i] = wr_run && reg_wdata[i] && reg_wdata[dtmr_pkg::RUN_BASE + i];
            sw_stop[i]  = wr_run && reg_wdata[i] && !reg_wdata[dtmr_pkg::RUN_BASE + i];
        end
    end

    // settings writes; reserved settings bits stay zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0_settings_q <= dtmr_pkg::SETTINGS_RST;
            t1_settings_q <= dtmr_pkg::SETTINGS_RST;
        end else if (reg_write) begin
            if (reg_addr == dtmr_pkg::ADDR_T0_SETTINGS) begin
                t0_settings_q <= reg_wdata & dtmr_pkg::SETTINGS_MASK;
            end
            if (reg_addr == dtmr_pkg::ADDR_T1_SETTINGS) begin
                t1_settings_q <= reg_wdata & dtmr_pkg::SETTINGS_MASK;
            end
        end
    end

    // reload bytes; a start event or a reload at zero copies them into a counter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0_rld_hi_q <= dtmr_pkg::RELOAD_RST;
            t0_rld_lo_q <= dtmr_pkg::RELOAD_RST;
            t1_rld_hi_q <= dtmr_pkg::RELOAD_RST;
            t1_rld_lo_q <= dtmr_pkg::RELOAD_RST;
        end else if (reg_write) begin
            unique case (reg_addr)
                dtmr_pkg::ADDR_T0_RLD_HI: t0_rld_hi_q <= reg_wdata;
                dtmr_pkg::ADDR_T0_RLD_LO: t0_rld_lo_q <= reg_wdata;
                dtmr_pkg::ADDR_T1_RLD_HI: t1_rld_hi_q <= reg_wdata;
                dtmr_pkg::ADDR_T1_RLD_LO: t1_rld_lo_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // interrupt mask, same layout as the status bits
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_q <= 2'h0;
        end else if (reg_write && reg_addr == dtmr_pkg::ADDR_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[1:0];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            dtmr_pkg::ADDR_RUN_CTRL:    rdata_d = {2'h0, t1_running, t0_running, 4'h0};
            dtmr_pkg::ADDR_T0_SETTINGS: rdata_d = t0_settings_q;
            dtmr_pkg::ADDR_T1_SETTINGS: rdata_d = t1_settings_q;
            dtmr_pkg::ADDR_T0_RLD_HI:   rdata_d = t0_rld_hi_q;
            dtmr_pkg::ADDR_T0_RLD_LO:   rdata_d = t0_rld_lo_q;
            dtmr_pkg::ADDR_T1_RLD_HI:   rdata_d = t1_rld_hi_q;
            dtmr_pkg::ADDR_T1_RLD_LO:   rdata_d = t1_rld_lo_q;
            dtmr_pkg::ADDR_T0_CNT_HI:   rdata_d = t0_count[15:8];
            dtmr_pkg::ADDR_T0_CNT_LO:   rdata_d = t0_count[7:0];
            dtmr_pkg::ADDR_T1_CNT_HI:   rdata_d = t1_count[15:8];
            dtmr_pkg::ADDR_T1_CNT_LO:   rdata_d = t1_count[7:0];
            dtmr_pkg::ADDR_IRQ_STATUS:  rdata_d = {6'h00, irq_status_q};
            dtmr_pkg::ADDR_IRQ_MASK:    rdata_d = {6'h00, irq_mask_q};
            default:                    rdata_d = 8'h00;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? rdata_d : 8'h00;
        end
    end

    // slow tick: one pulse every SLOW_DIV fast cycles
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q       <= '0;
            slow_tick_q <= 1'b0;
        end else begin
            slow_tick_q <= (div_q == $bits(div_q)'(SLOW_DIV - 1));
            div_q <= (div_q == $bits(div_q)'(SLOW_DIV - 1)) ? '0 : div_q + 1'b1;
        end
    end

    // count received bits of a frame; halt pulse after the fourth
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_bits_q <= 3'h0;
            rx_halt_q <= 1'b0;
        end else begin
            rx_halt_q <= 1'b0;
            if (rx_frame_start) begin
                rx_bits_q <= 3'h0;
            end else if (rx_bit_pulse && rx_bits_q < 3'(dtmr_pkg::RX_HALT_BITS)) begin
                rx_bits_q <= rx_bits_q + 1'b1;
                rx_halt_q <= (rx_bits_q == 3'(dtmr_pkg::RX_HALT_BITS - 1));
            end
        end
    end

    // trim edge pin crosses in via two flops before edge detection
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trim_meta_q <= 1'b0;
            trim_sync_q <= 1'b0;
            trim_prev_q <= 1'b0;
        end else begin
            trim_meta_q <= trim_edge_pin;
            trim_sync_q <= trim_meta_q;
            trim_prev_q <= trim_sync_q;
        end
    end
    assign trim_rise = trim_sync_q && !trim_prev_q;

    // per-timer start and stop events
    logic t0_start;
    logic t1_start;
    logic t0_stop;
    logic t1_stop;

    // trimming: rising edge starts when idle, stops when running
    always_comb begin
        t0_start = sw_start[0]
                   || auto_start(t0_settings_q, tx_end_pulse, trim_rise, t0_running);
        t1_start = sw_start[1]
                   || auto_start(t1_settings_q, tx_end_pulse, trim_rise, t1_running);
        t0_stop  = sw_stop[0]
                   || auto_stop(t0_settings_q, trim_rise, t0_running, rx_halt_q);
        t1_stop  = sw_stop[1]
                   || auto_stop(t1_settings_q, trim_rise, t1_running, rx_halt_q);
    end

    // tick selection per timer, with cascading
    logic t0_tick;
    logic t1_tick;
    assign t0_tick = pick_tick(t0_settings_q[dtmr_pkg::CLKSEL_MSB:dtmr_pkg::CLKSEL_LSB],
                               slow_tick_q, timer2_underflow, t1_uf);
    assign t1_tick = pick_tick(t1_settings_q[dtmr_pkg::CLKSEL_MSB:dtmr_pkg::CLKSEL_LSB],
                               slow_tick_q, t0_uf, timer2_underflow);

    dtmr_timer #(.WIDTH(WIDTH)) u_timer0 (
        .sys_clk        (sys_clk),
        .reset_n        (reset_n),
        .reload_value   ({t0_rld_hi_q, t0_rld_lo_q}),
        .start_pulse    (t0_start),
        .stop_pulse     (t0_stop),
        .tick           (t0_tick),
        .reload_on_zero (t0_settings_q[dtmr_pkg::RELOAD_BIT]),
        .wrap_on_zero   (start_mode(t0_settings_q) == dtmr_pkg::START_TRIM_UF),
        .count_q        (t0_count),
        .running_q      (t0_running),
        .underflow_q    (t0_uf)
    );

    dtmr_timer #(.WIDTH(WIDTH)) u_timer1 (
        .sys_clk        (sys_clk),
        .reset_n        (reset_n),
        .reload_value   ({t1_rld_hi_q, t1_rld_lo_q}),
        .start_pulse    (t1_start),
        .stop_pulse     (t1_stop),
        .tick           (t1_tick),
        .reload_on_zero (t1_settings_q[dtmr_pkg::RELOAD_BIT]),
        .wrap_on_zero   (start_mode(t1_settings_q) == dtmr_pkg::START_TRIM_UF),
        .count_q        (t1_count),
        .running_q      (t1_running),
        .underflow_q    (t1_uf)
    );

    // write-one-to-clear strobes for the status bits
    logic [1:0] irq_clr;
    assign irq_clr = (reg_write && reg_addr == dtmr_pkg::ADDR_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0;

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_q <= 2'h0;
        end else begin
            irq_status_q[dtmr_pkg::IRQ_T0] <= t0_uf
                                             || (irq_status_q[dtmr_pkg::IRQ_T0] && !irq_clr[0]);
            irq_status_q[dtmr_pkg::IRQ_T1] <= t1_uf
                                             || (irq_status_q[dtmr_pkg::IRQ_T1] && !irq_clr[1]);
        end
    end

    // irq level; lags status by one cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // underflow pulses out, registered so other timers see a clean pulse
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer0_underflow <= 1'b0;
            timer1_underflow <= 1'b0;
        end else begin
            timer0_underflow <= t0_uf;
            timer1_underflow <= t1_uf;
        end
    end
endmodule

// ---- dtmr_top_chk.sv ----
// port-level assertions for the dual reload countdown timers
// assumes a bind onto dtmr_top and a single sys_clk domain
module dtmr_top_chk #(
    parameter int WIDTH    = 16,
    parameter int SLOW_DIV = 64
) (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq,
    input wire logic       timer1_underflow
);
    logic [15:0] t0_rld_q;
    logic [15:0] t1_rld_q;
    logic [7:0]  mask_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // shadow copies of written bytes, so loads can be predicted
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            t0_rld_q <= 16'h0000;
            t1_rld_q <= 16'h0000;
            mask_q   <= 8'h00;
        end else if (reg_write) begin
            case (reg_addr)
                8'h10: t0_rld_q[15:8] <= reg_wdata;
                8'h11: t0_rld_q[7:0] <= reg_wdata;
                8'h15: t1_rld_q[15:8] <= reg_wdata;
                8'h16: t1_rld_q[7:0] <= reg_wdata;
                8'h31: mask_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data stands one cycle only, so stale bytes never linger
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not cleared");
    a_reload_rdback: assert property (
        reg_write && reg_addr inside {8'h10, 8'h11, 8'h15, 8'h16} ##1
        reg_read && reg_addr == $past(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reload byte read back wrong");
    a_settings_rsvd: assert property (
        reg_read && (reg_addr == 8'h0F || reg_addr == 8'h14) |=> !reg_rdata[6] && !reg_rdata[2])
        else $error("reserved settings bit reads one");
    // a start writes the reload value into the counter on that edge
    a_t1_start_load: assert property (
        reg_write && reg_addr == 8'h0E && reg_wdata[1] && reg_wdata[5] ##1
        reg_read && reg_addr == 8'h17 |=> reg_rdata == t1_rld_q[15:8])
        else $error("timer1 start did not load reload value");
    a_t0_start_load: assert property (
        reg_write && reg_addr == 8'h0E && reg_wdata[0] && reg_wdata[4] ##1
        reg_read && reg_addr == 8'h13 |=> reg_rdata == t0_rld_q[7:0])
        else $error("timer0 start did not load reload value");
    // interrupt level follows flag and mask with a short lag
    a_uf_raises_irq: assert property (
        timer1_underflow && mask_q[1] |-> ##[0:2] irq)
        else $error("unmasked underflow gave no interrupt");
    a_irq_needs_mask: assert property ($rose(irq) |-> $past(mask_q) != 8'h00)
        else $error("interrupt rose with everything masked");
    a_mask_off_irq: assert property (
        reg_write && reg_addr == 8'h31 && reg_wdata == 8'h00 ##1
        !(reg_write && reg_addr == 8'h31) |=> !irq)
        else $error("interrupt high with mask cleared");
endmodule

// ---- dual_reload_countdown_timers_bench.sv ----
// self-checking bench for the dual reload countdown timers
// assumes dtmr_top built with the slow tick divider shortened to 8
module dual_reload_countdown_timers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic       w;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dtmr_row_t;
    logic       sys_clk;
    logic       reset_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic [4:0] ev;
    logic       irq;
    logic       timer0_underflow;
    logic       timer1_underflow;
    logic [7:0] q;
    int         n;
    int         fail_count;
    int         cmp_count;
    int         cycles;
    dtmr_row_t  rows [0:14];

    dtmr_top #(.WIDTH(16), .SLOW_DIV(8)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .rx_bit_pulse(ev[2]), .rx_frame_start(ev[1]), .tx_end_pulse(ev[0]),
        .trim_edge_pin(ev[3]), .timer2_underflow(ev[4]), .irq(irq),
        .timer0_underflow(timer0_underflow), .timer1_underflow(timer1_underflow));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'h0;
    endtask
    // read strobe follows the write with no gap
    task automatic wr_rd(input logic [7:0] wa, input logic [7:0] d, input logic [7:0] ra);
        wr(wa, d);
        reg_read <= 1'h1;
        reg_addr <= ra;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 q = reg_rdata;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'h0;
        #1 q = reg_rdata;
    endtask
    task automatic run_is(input logic exp);
        rd(8'h0E);
        chk({7'h00, q[5]}, {7'h00, exp});
    endtask
    task automatic pulse(input int k);
        @(posedge sys_clk);
        ev[k] <= 1'h1;
        @(posedge sys_clk);
        ev[k] <= 1'h0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    // counts falling edges until the underflow pulse, bounded against hangs
    task automatic wait_uf();
        n = 0;
        @(negedge sys_clk);
        while (timer1_underflow !== 1'h1 && n < 200) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 200) chk(8'h00, 8'h01);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // free-running clock, 20 ns period
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        {reset_n, reg_write, reg_read, ev} = '0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        {fail_count, cmp_count, cycles, n} = '0;
        rows = '{{1'h0, 8'h10, 8'h00, 8'h00}, {1'h0, 8'h14, 8'h00, 8'h00},
            {1'h0, 8'h17, 8'h00, 8'h00}, {1'h0, 8'h0E, 8'h00, 8'h00},
            {1'h1, 8'h10, 8'hA5, 8'hA5}, {1'h1, 8'h11, 8'h5A, 8'h5A},
            {1'h1, 8'h15, 8'hFF, 8'hFF}, {1'h1, 8'h16, 8'h00, 8'h00},
            {1'h1, 8'h14, 8'hFF, 8'hBB}, {1'h1, 8'h0F, 8'hFF, 8'hBB},
            {1'h1, 8'h0F, 8'h00, 8'h00}, {1'h1, 8'h14, 8'h00, 8'h00},
            {1'h0, 8'h12, 8'h00, 8'h00}, {1'h0, 8'h40, 8'h00, 8'h00},
            {1'h1, 8'h31, 8'h02, 8'h02}};
        cyc(6);
        reset_n <= 1'h1;
        // reset values, read-write bytes, reserved bits, an unmapped place
        foreach (rows[i]) begin
            if (rows[i].w) wr_rd(rows[i].a, rows[i].d, rows[i].a);
            else rd(rows[i].a);
            chk(q, rows[i].e);
        end
        // one-shot on the fast clock: exact latency, stop at zero, flag
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h03);
        wr(8'h0E, 8'h22);
        wait_uf();
        chk(8'(n), 8'h05);
        run_is(1'h0);
        chk({7'h00, irq}, 8'h01);
        rd(8'h18);
        chk(q, 8'h00);
        rd(8'h30);
        chk(q, 8'h02);
        wr(8'h30, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        // auto reload, reload write while running, run-control enables
        wr(8'h16, 8'h40);
        wr(8'h14, 8'h08);
        wr(8'h0E, 8'h22);
        wait_uf();
        run_is(1'h1);
        wr(8'h15, 8'h03);
        rd(8'h17);
        chk(q, 8'h00);
        wr(8'h0E, 8'h20);
        run_is(1'h1);
        wr(8'h0E, 8'h02);
        run_is(1'h0);
        wr_rd(8'h0E, 8'h22, 8'h17);
        chk(q, 8'h03);
        // transmit-end start, halt after four received bits only when enabled
        wr(8'h0E, 8'h02);
        wr(8'h14, 8'h00);
        pulse(0);
        run_is(1'h0);
        for (int h = 0; h < 2; h++) begin
            wr(8'h14, (h == 1) ? 8'h90 : 8'h10);
            pulse(0);
            run_is(1'h1);
            pulse(1);
            repeat (4) pulse(2);
            cyc(2);
            run_is(h == 0);
        end
        // trimming: pin edges start and stop, receive halt has no effect
        wr(8'h0E, 8'h02);
        wr(8'h14, 8'hA0);
        pulse(3);
        cyc(3);
        run_is(1'h1);
        pulse(1);
        repeat (4) pulse(2);
        run_is(1'h1);
        pulse(3);
        cyc(3);
        run_is(1'h0);
        wr(8'h15, 8'h00);
        wr(8'h16, 8'h02);
        wr(8'h14, 8'h30);
        pulse(3);
        wait_uf();
        run_is(1'h1);
        // slow tick, then cascading from the external and timer0 underflows
        wr(8'h0E, 8'h02);
        wr(8'h14, 8'h01);
        wr(8'h0E, 8'h22);
        wait_uf();
        chk(8'(n >= 16 && n <= 36), 8'h01);
        wr(8'h14, 8'h03);
        wr(8'h0E, 8'h22);
        cyc(20);
        rd(8'h18);
        chk(q, 8'h02);
        repeat (3) pulse(4);
        wait_uf();
        chk(8'(n < 8), 8'h01);
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h01);
        wr(8'h0F, 8'h08);
        wr(8'h14, 8'h02);
        wr_rd(8'h0E, 8'h33, 8'h13);
        chk(q, 8'h01);
        wait_uf();
        chk(8'(n > 6 && n < 40), 8'h01);
        // timer0 underflow alternates while it reloads from one
        q[0] = timer0_underflow;
        @(negedge sys_clk);
        chk({7'h00, q[0] ^ timer0_underflow}, 8'h01);
        // timer0: transmit-end start, then halt after four received bits
        wr(8'h10, 8'h01);
        wr(8'h0F, 8'h90);
        pulse(0);
        rd(8'h0E);
        chk({7'h00, q[4]}, 8'h01);
        pulse(1);
        repeat (4) pulse(2);
        cyc(2);
        rd(8'h0E);
        chk({7'h00, q[4]}, 8'h00);
        // masking the flag, then a reset in mid-run
        wr(8'h31, 8'h00);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        reset_n <= 1'h0;
        cyc(2);
        reset_n <= 1'h1;
        run_is(1'h0);
        rd(8'h11);
        chk(q, 8'h00);
        give_verdict();
    end
endmodule

bind dtmr_top dtmr_top_chk #(.WIDTH(WIDTH), .SLOW_DIV(SLOW_DIV)) u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .timer1_underflow(timer1_underflow));
